/* logic/scu_pkg.sv */
// package: register map, field positions, reset values and carriers for the config bank
package scu_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [8:0] ADDR_CLKGEN = 9'h020;
    localparam logic [8:0] ADDR_CORE = 9'h028;
    localparam logic [8:0] ADDR_AFE = 9'h030;
    localparam logic [8:0] ADDR_BIAS_LO = 9'h040;
    localparam logic [8:0] ADDR_BIAS_HI = 9'h047;
    localparam logic [8:0] ADDR_SEROUT = 9'h070;
    localparam logic [8:0] ADDR_BLKCAL_LO = 9'h080;
    localparam logic [8:0] ADDR_BLKCAL_HI = 9'h081;
    localparam logic [8:0] ADDR_SYNCCODE_LO = 9'h081;
    localparam logic [8:0] ADDR_SYNCCODE_HI = 9'h087;
    localparam logic [8:0] ADDR_TESTPAT_LO = 9'h090;
    localparam logic [8:0] ADDR_TESTPAT_HI = 9'h096;
    localparam logic [8:0] ADDR_SEQCTL = 9'h0C0;
    localparam logic [8:0] ADDR_WINSEL = 9'h0C3;
    localparam logic [8:0] ADDR_BLACK = 9'h0C5;
    localparam logic [8:0] ADDR_DUMMY = 9'h0C6;
    localparam logic [8:0] ADDR_EXP_LO = 9'h0C7;
    localparam logic [8:0] ADDR_EXP_HI = 9'h0CB;
    localparam logic [8:0] ADDR_GAIN = 9'h0CC;
    localparam logic [8:0] ADDR_SYNC = 9'h0CE;
    localparam logic [8:0] ADDR_STATUS = 9'h0CF;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int SEQ_ENABLE_BIT = 0;
    localparam int SEQ_ROLLING_BIT = 1;
    localparam int SEQ_TRIGGERED_BIT = 2;
    localparam int SEQ_SLAVE_BIT = 3;
    localparam int SEQ_SUBSAMPLE_BIT = 7;
    localparam int SEQ_BINNING_BIT = 8;
    localparam int GAIN_LATCOMP_BIT = 13;
    localparam int SYNC_BLACK_BIT = 0;
    localparam int SYNC_DUMMY_BIT = 1;
    localparam int SYNC_EXP_BIT = 2;
    localparam int SYNC_GAIN_BIT = 3;
    localparam int SYNC_ROI_BIT = 4;
    localparam int SYNC_BLANKWIN_BIT = 8;
    localparam int SYNC_EXPMODE_BIT = 9;
    localparam int EXP_WORDS = 5;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_SYNC = 16'h001F;
    localparam logic [15:0] RST_WINSEL = 16'h0001;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic en;
        logic [8:0] addr;
        logic [15:0] data;
    } scu_wr_t;

    typedef struct packed {
        logic subsample;
        logic binning;
        logic [7:0] window;
        logic [15:0] black_lines;
        logic [15:0] dummy_lines;
        logic [EXP_WORDS-1:0][15:0] exposure;
        logic [15:0] gain;
    } scu_active_t;

    typedef struct packed {
        logic sync_codes;
        logic black_cal;
        logic test_pattern;
    } scu_transient_t;

    typedef enum logic {FRAME_IMAGE, FRAME_BLANK} scu_frame_t;

endpackage : scu_pkg

/* logic/scu_config_sync.sv */
// module: configuration bank with frame-synchronised shadow and active register sets
`timescale 1ns/100ps
module scu_config_sync (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire scu_pkg::scu_wr_t i_wr,
    input wire logic i_rd_en,
    input wire logic [8:0] i_rd_addr,
    input wire logic i_frame_start,
    output logic [15:0] o_rd_data,
    output scu_pkg::scu_active_t o_active,
    output logic [15:0] o_clkgen_cfg,
    output logic [15:0] o_core_cfg,
    output logic [15:0] o_afe_cfg,
    output logic [15:0] o_serout_cfg,
    output logic [5:0] o_seq_mode,
    output logic o_seq_enable,
    output logic o_blank_frame,
    output logic o_training_pattern,
    output scu_pkg::scu_transient_t o_transient
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // address range decode, used for bias, exposure and transient groups
    function automatic logic in_range(input logic [8:0] a, input logic [8:0] lo,
                                      input logic [8:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic logic wr_hit(input scu_pkg::scu_wr_t w, input logic [8:0] a);
        wr_hit = w.en && (w.addr == a);
    endfunction : wr_hit

    // ------------------------------------------------------------------
    // shadow registers written by the host
    // ------------------------------------------------------------------
    logic [15:0] clkgen_reg, clkgen_next;
    logic [15:0] core_reg, core_next;
    logic [15:0] afe_reg, afe_next;
    logic [7:0][15:0] bias_reg, bias_next;
    logic [15:0] serout_reg, serout_next;
    logic [15:0] seqctl_reg, seqctl_next;
    logic [15:0] winsel_reg, winsel_next;
    logic [15:0] black_reg, black_next;
    logic [15:0] dummy_reg, dummy_next;
    logic [scu_pkg::EXP_WORDS-1:0][15:0] exp_reg, exp_next;
    logic [15:0] gain_reg, gain_next;
    logic [15:0] sync_reg, sync_next;

    // static registers are plain storage; the host keeps them still while
    // the sequencer runs, so no protection logic is spent here
    always_comb
    begin
        clkgen_next = clkgen_reg;
        core_next = core_reg;
        afe_next = afe_reg;
        bias_next = bias_reg;
        serout_next = serout_reg;
        seqctl_next = seqctl_reg;
        winsel_next = winsel_reg;
        black_next = black_reg;
        dummy_next = dummy_reg;
        exp_next = exp_reg;
        gain_next = gain_reg;
        sync_next = sync_reg;
        if (i_wr.en)
        begin
            case (i_wr.addr)
                scu_pkg::ADDR_CLKGEN: clkgen_next = i_wr.data;
                scu_pkg::ADDR_CORE: core_next = i_wr.data;
                scu_pkg::ADDR_AFE: afe_next = i_wr.data;
                scu_pkg::ADDR_SEROUT: serout_next = i_wr.data;
                scu_pkg::ADDR_SEQCTL: seqctl_next = i_wr.data;
                scu_pkg::ADDR_WINSEL: winsel_next = i_wr.data;
                scu_pkg::ADDR_BLACK: black_next = i_wr.data;
                scu_pkg::ADDR_DUMMY: dummy_next = i_wr.data;
                scu_pkg::ADDR_GAIN: gain_next = i_wr.data;
                scu_pkg::ADDR_SYNC: sync_next = i_wr.data;
                default:
                begin
                    if (in_range(i_wr.addr, scu_pkg::ADDR_BIAS_LO, scu_pkg::ADDR_BIAS_HI))
                        bias_next[i_wr.addr[2:0]] = i_wr.data;
                    if (in_range(i_wr.addr, scu_pkg::ADDR_EXP_LO, scu_pkg::ADDR_EXP_HI))
                        exp_next[3'(i_wr.addr - scu_pkg::ADDR_EXP_LO)] = i_wr.data;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            clkgen_reg <= scu_pkg::RST_ZERO;
            core_reg <= scu_pkg::RST_ZERO;
            afe_reg <= scu_pkg::RST_ZERO;
            bias_reg <= '0;
            serout_reg <= scu_pkg::RST_ZERO;
            seqctl_reg <= scu_pkg::RST_ZERO;
            winsel_reg <= scu_pkg::RST_WINSEL;
            black_reg <= scu_pkg::RST_ZERO;
            dummy_reg <= scu_pkg::RST_ZERO;
            exp_reg <= '0;
            gain_reg <= scu_pkg::RST_ZERO;
            sync_reg <= scu_pkg::RST_SYNC;
        end
        else
        begin
            clkgen_reg <= clkgen_next;
            core_reg <= core_next;
            afe_reg <= afe_next;
            bias_reg <= bias_next;
            serout_reg <= serout_next;
            seqctl_reg <= seqctl_next;
            winsel_reg <= winsel_next;
            black_reg <= black_next;
            dummy_reg <= dummy_next;
            exp_reg <= exp_next;
            gain_reg <= gain_next;
            sync_reg <= sync_next;
        end
    end

    // ------------------------------------------------------------------
    // change tracking and frame-start transfer
    // ------------------------------------------------------------------
    logic sync_black, sync_dummy, sync_exp, sync_gain, sync_roi;
    logic rolling, exp_direct, need_blank;
    logic black_chg_reg, black_chg_next;
    logic dummy_chg_reg, dummy_chg_next;
    logic win_chg_reg, win_chg_next;
    scu_pkg::scu_active_t act_reg, act_next;
    logic [scu_pkg::EXP_WORDS-1:0][15:0] exp_stage_reg, exp_stage_next;
    logic [15:0] gain_stage_reg, gain_stage_next;
    scu_pkg::scu_frame_t frame_reg, frame_next;
    scu_pkg::scu_transient_t trans_reg, trans_next;

    assign sync_black = sync_reg[scu_pkg::SYNC_BLACK_BIT];
    assign sync_dummy = sync_reg[scu_pkg::SYNC_DUMMY_BIT];
    assign sync_exp = sync_reg[scu_pkg::SYNC_EXP_BIT];
    assign sync_gain = sync_reg[scu_pkg::SYNC_GAIN_BIT];
    assign sync_roi = sync_reg[scu_pkg::SYNC_ROI_BIT];
    assign rolling = seqctl_reg[scu_pkg::SEQ_ROLLING_BIT];
    // triggered master global mode with sync mode set skips the exposure stage
    assign exp_direct = sync_reg[scu_pkg::SYNC_EXPMODE_BIT] && !rolling
                        && seqctl_reg[scu_pkg::SEQ_TRIGGERED_BIT]
                        && !seqctl_reg[scu_pkg::SEQ_SLAVE_BIT];
    // blank only for changes that are actually applied at this frame start
    assign need_blank = rolling && ((sync_black && black_chg_reg)
                        || (sync_dummy && dummy_chg_reg)
                        || (sync_roi && win_chg_reg
                            && sync_reg[scu_pkg::SYNC_BLANKWIN_BIT]));

    // change flags: a write landing on the frame-start cycle sets, so set wins
    always_comb
    begin
        black_chg_next = black_chg_reg;
        dummy_chg_next = dummy_chg_reg;
        win_chg_next = win_chg_reg;
        if (i_frame_start && sync_black)
            black_chg_next = 1'b0;
        if (i_frame_start && sync_dummy)
            dummy_chg_next = 1'b0;
        if (i_frame_start && sync_roi)
            win_chg_next = 1'b0;
        if (wr_hit(i_wr, scu_pkg::ADDR_BLACK) && i_wr.data != black_reg)
            black_chg_next = 1'b1;
        if (wr_hit(i_wr, scu_pkg::ADDR_DUMMY) && i_wr.data != dummy_reg)
            dummy_chg_next = 1'b1;
        // only a different selection counts; window geometry writes never do
        if (wr_hit(i_wr, scu_pkg::ADDR_WINSEL) && i_wr.data != winsel_reg)
            win_chg_next = 1'b1;
    end

    // active set moves only at frame start and only for synced groups
    always_comb
    begin
        act_next = act_reg;
        exp_stage_next = exp_stage_reg;
        gain_stage_next = gain_stage_reg;
        if (i_frame_start)
        begin
            if (sync_roi)
            begin
                act_next.subsample = seqctl_reg[scu_pkg::SEQ_SUBSAMPLE_BIT];
                act_next.binning = seqctl_reg[scu_pkg::SEQ_BINNING_BIT];
                act_next.window = winsel_reg[7:0];
            end
            if (sync_black)
                act_next.black_lines = black_reg;
            if (sync_dummy)
                act_next.dummy_lines = dummy_reg;
            if (sync_exp)
            begin
                exp_stage_next = exp_reg;
                act_next.exposure = exp_direct ? exp_reg : exp_stage_reg;
            end
            if (sync_gain)
            begin
                gain_stage_next = gain_reg;
                // latency compensation lines gain up with the staged exposure
                act_next.gain = gain_reg[scu_pkg::GAIN_LATCOMP_BIT]
                                ? gain_stage_reg : gain_reg;
            end
        end
    end

    // frame state: blanked after a start with need_blank, image again at the first start without it
    always_comb
    begin
        frame_next = frame_reg;
        if (i_frame_start)
        begin
            case (frame_reg)
                scu_pkg::FRAME_IMAGE: frame_next = need_blank ? scu_pkg::FRAME_BLANK
                                                              : scu_pkg::FRAME_IMAGE;
                scu_pkg::FRAME_BLANK: frame_next = need_blank ? scu_pkg::FRAME_BLANK
                                                              : scu_pkg::FRAME_IMAGE;
                default: frame_next = scu_pkg::FRAME_IMAGE;
            endcase
        end
    end

    // transient markers cover the frame in which the write lands
    always_comb
    begin
        trans_next = trans_reg;
        if (i_frame_start)
            trans_next = '0;
        if (i_wr.en && in_range(i_wr.addr, scu_pkg::ADDR_SYNCCODE_LO,
                                scu_pkg::ADDR_SYNCCODE_HI))
            trans_next.sync_codes = 1'b1;
        if (i_wr.en && (in_range(i_wr.addr, scu_pkg::ADDR_BLKCAL_LO, scu_pkg::ADDR_BLKCAL_HI)
                        || (i_wr.addr == scu_pkg::ADDR_BLACK)))
            trans_next.black_cal = 1'b1;
        if (i_wr.en && in_range(i_wr.addr, scu_pkg::ADDR_TESTPAT_LO,
                                scu_pkg::ADDR_TESTPAT_HI))
            trans_next.test_pattern = 1'b1;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            black_chg_reg <= 1'b0;
            dummy_chg_reg <= 1'b0;
            win_chg_reg <= 1'b0;
            act_reg <= '0;
            exp_stage_reg <= '0;
            gain_stage_reg <= scu_pkg::RST_ZERO;
            frame_reg <= scu_pkg::FRAME_IMAGE;
            trans_reg <= '0;
        end
        else
        begin
            black_chg_reg <= black_chg_next;
            dummy_chg_reg <= dummy_chg_next;
            win_chg_reg <= win_chg_next;
            act_reg <= act_next;
            exp_stage_reg <= exp_stage_next;
            gain_stage_reg <= gain_stage_next;
            frame_reg <= frame_next;
            trans_reg <= trans_next;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    logic [15:0] rd_reg, rd_next;

    // registered read; unmapped addresses return zero
    always_comb
    begin
        rd_next = rd_reg;
        if (i_rd_en)
        begin
            case (i_rd_addr)
                scu_pkg::ADDR_CLKGEN: rd_next = clkgen_reg;
                scu_pkg::ADDR_CORE: rd_next = core_reg;
                scu_pkg::ADDR_AFE: rd_next = afe_reg;
                scu_pkg::ADDR_SEROUT: rd_next = serout_reg;
                scu_pkg::ADDR_SEQCTL: rd_next = seqctl_reg;
                scu_pkg::ADDR_WINSEL: rd_next = winsel_reg;
                scu_pkg::ADDR_BLACK: rd_next = black_reg;
                scu_pkg::ADDR_DUMMY: rd_next = dummy_reg;
                scu_pkg::ADDR_GAIN: rd_next = gain_reg;
                scu_pkg::ADDR_SYNC: rd_next = sync_reg;
                scu_pkg::ADDR_STATUS: rd_next = {9'h000, trans_reg,
                    win_chg_reg, dummy_chg_reg, black_chg_reg,
                    frame_reg == scu_pkg::FRAME_BLANK};
                default:
                begin
                    rd_next = 16'h0000;
                    if (in_range(i_rd_addr, scu_pkg::ADDR_BIAS_LO, scu_pkg::ADDR_BIAS_HI))
                        rd_next = bias_reg[i_rd_addr[2:0]];
                    if (in_range(i_rd_addr, scu_pkg::ADDR_EXP_LO, scu_pkg::ADDR_EXP_HI))
                        rd_next = exp_reg[3'(i_rd_addr - scu_pkg::ADDR_EXP_LO)];
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rd_reg <= 16'h0000;
        else
            rd_reg <= rd_next;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_rd_data = rd_reg;
    assign o_active = act_reg;
    assign o_clkgen_cfg = clkgen_reg;
    assign o_core_cfg = core_reg;
    assign o_afe_cfg = afe_reg;
    assign o_serout_cfg = serout_reg;
    assign o_seq_mode = seqctl_reg[6:1];
    assign o_seq_enable = seqctl_reg[scu_pkg::SEQ_ENABLE_BIT];
    assign o_blank_frame = (frame_reg == scu_pkg::FRAME_BLANK);
    // training patterns go out on data and sync channels for the blank frame
    assign o_training_pattern = (frame_reg == scu_pkg::FRAME_BLANK);
    assign o_transient = trans_reg;

endmodule : scu_config_sync

/* tb/scu_config_sync_assertions.sv */
// checker: frame-synchronised update properties of the config bank
`timescale 1ns/100ps
module scu_config_sync_assertions (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire scu_pkg::scu_wr_t i_wr,
    input wire logic i_frame_start,
    input wire scu_pkg::scu_active_t o_active,
    input wire logic [5:0] o_seq_mode,
    input wire logic o_blank_frame,
    input wire logic o_training_pattern,
    input wire scu_pkg::scu_transient_t o_transient
);
    // ----------------------------------------------------------------
    // shadow tracking
    // ----------------------------------------------------------------
    logic [15:0] sync_reg, sync_next, seq_reg, seq_next;
    logic [15:0] blk_reg, blk_next, gain_reg, gain_next;

    // shadows seen from the write port, so transfers can be predicted
    always_comb
    begin
        sync_next = sync_reg;
        seq_next = seq_reg;
        blk_next = blk_reg;
        gain_next = gain_reg;
        if (i_wr.en && i_wr.addr == 9'h0CE) sync_next = i_wr.data;
        if (i_wr.en && i_wr.addr == 9'h0C0) seq_next = i_wr.data;
        if (i_wr.en && i_wr.addr == 9'h0C5) blk_next = i_wr.data;
        if (i_wr.en && i_wr.addr == 9'h0CC) gain_next = i_wr.data;
    end

    // reset mirrors the bank, else the first frame would mispredict
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync_reg <= 16'h001F;
            seq_reg <= 16'h0000;
            blk_reg <= 16'h0000;
            gain_reg <= 16'h0000;
        end
        else
        begin
            sync_reg <= sync_next;
            seq_reg <= seq_next;
            blk_reg <= blk_next;
            gain_reg <= gain_next;
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    active_hold_a: assert property (!i_frame_start |=> $stable(o_active))
        else $error("active set moved outside a frame start");
    blank_hold_a: assert property (!i_frame_start |=> $stable(o_blank_frame))
        else $error("blank changed inside a frame");
    training_blank_a: assert property (o_training_pattern == o_blank_frame)
        else $error("training output differs from blank");
    blank_rolling_a: assert property ($rose(o_blank_frame) |-> o_seq_mode[0])
        else $error("blank raised outside rolling shutter");
    frozen_black_a: assert property (i_frame_start && !sync_reg[0]
        |=> $stable(o_active.black_lines))
        else $error("frozen black lines changed");
    black_apply_a: assert property (i_frame_start && sync_reg[0]
        |=> o_active.black_lines == $past(blk_reg))
        else $error("black lines not taken at frame start");
    roi_apply_a: assert property (i_frame_start && sync_reg[4]
        |=> o_active.subsample == $past(seq_reg[7])
        && o_active.binning == $past(seq_reg[8]))
        else $error("subsample or binning not taken at frame start");
    gain_apply_a: assert property (i_frame_start && sync_reg[3] && !gain_reg[13]
        |=> o_active.gain == $past(gain_reg))
        else $error("gain not taken at frame start");
    pattern_flag_a: assert property (i_wr.en && i_wr.addr inside {[9'h090:9'h096]}
        |=> o_transient.test_pattern)
        else $error("test pattern flag missing");
    code_flag_a: assert property (i_wr.en && i_wr.addr inside {[9'h081:9'h087]}
        |=> o_transient.sync_codes)
        else $error("sync code flag missing");
    flag_clear_a: assert property (i_frame_start && !i_wr.en |=> o_transient == 3'b000)
        else $error("transient flags kept past frame start");

    cover property (o_blank_frame);
    cover property (i_frame_start && !sync_reg[0]);
    cover property ($rose(o_transient.test_pattern));
endmodule : scu_config_sync_assertions

/* tb/scu_host_model.sv */
// partner: host controller that writes and reads the bank
`timescale 1ns/100ps
module scu_host_model (
    input wire logic i_core_clk,
    input wire logic [15:0] i_rd_data,
    output scu_pkg::scu_wr_t o_wr,
    output logic o_rd_en,
    output logic [8:0] o_rd_addr
);
    logic seq_on = 1'b0;
    logic [5:0] mode = 6'h00;

    // idle bus at time zero
    initial
    begin
        o_wr = '0;
        o_rd_en = 1'b0;
        o_rd_addr = 9'h000;
    end

    // one write; released lines show the inverse, never the old value
    task automatic write(input logic [8:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a > 9'h0CF) return;
        if (seq_on && a inside {9'h020, 9'h028, 9'h030, [9'h040:9'h047], 9'h070}) return;
        if (a == 9'h0C0 && seq_on) v[6:1] = mode;
        if (a == 9'h0C0) seq_on = v[0];
        if (a == 9'h0C0) mode = v[6:1];
        @(negedge i_core_clk);
        o_wr <= '{1'b1, a, v};
        @(negedge i_core_clk);
        o_wr <= '{1'b0, ~a, ~v};
    endtask : write

    // one read; data is taken a cycle after the strobe
    task automatic read(input logic [8:0] a, output logic [15:0] d);
        @(negedge i_core_clk);
        o_rd_en <= 1'b1;
        o_rd_addr <= a;
        @(negedge i_core_clk);
        o_rd_en <= 1'b0;
        o_rd_addr <= ~a;
        d = i_rd_data;
    endtask : read
endmodule : scu_host_model

/* tb/scu_config_sync_tb_top.sv */
// testbench: random host traffic and frame starts against a reference model
`timescale 1ns/100ps
module scu_config_sync_tb_top;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_frame_start = 1'b0;
    scu_pkg::scu_wr_t i_wr;
    logic i_rd_en;
    logic [8:0] i_rd_addr;
    logic [15:0] o_rd_data, o_clkgen_cfg, o_core_cfg, o_afe_cfg, o_serout_cfg;
    scu_pkg::scu_active_t o_active;
    logic [5:0] o_seq_mode;
    logic o_seq_enable, o_blank_frame, o_training_pattern;
    scu_pkg::scu_transient_t o_transient;
    // reference model: shadows, staged values, active set, pending changes
    scu_pkg::scu_active_t stg = '0, act = '0, sh = '{window: 8'h01, default: '0};
    scu_pkg::scu_transient_t tr = '0;
    logic [15:0] sync = 16'h001F, seq = 16'h0000, rd, v;
    logic [63:0] st;
    logic pb = 1'b0, pd = 1'b0, pw = 1'b0, blank;
    logic [8:0] ra [4] = '{9'h0CE, 9'h0C3, 9'h0C5, 9'h0D0};
    logic [15:0] rv [4] = '{16'h001F, 16'h0001, 16'h0000, 16'h0000};
    logic [8:0] sa [4] = '{9'h020, 9'h028, 9'h030, 9'h070};
    int fail_count = 0;
    int checks = 0;

    // 100 MHz core clock
    initial forever #5 i_core_clk = ~i_core_clk;

    scu_config_sync dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_wr(i_wr),
        .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .i_frame_start(i_frame_start),
        .o_rd_data(o_rd_data), .o_active(o_active), .o_clkgen_cfg(o_clkgen_cfg),
        .o_core_cfg(o_core_cfg), .o_afe_cfg(o_afe_cfg), .o_serout_cfg(o_serout_cfg),
        .o_seq_mode(o_seq_mode), .o_seq_enable(o_seq_enable), .o_blank_frame(o_blank_frame),
        .o_training_pattern(o_training_pattern), .o_transient(o_transient));
    scu_host_model host_u (.i_core_clk(i_core_clk), .i_rd_data(o_rd_data), .o_wr(i_wr),
        .o_rd_en(i_rd_en), .o_rd_addr(i_rd_addr));

    task automatic check(input logic [159:0] seen, input logic [159:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    // host write plus the model's view of the shadows it lands in
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        host_u.write(a, d);
        if (a == 9'h0C0) {seq, sh.binning, sh.subsample} = {d, d[8], d[7]};
        if (a == 9'h0C3) pw |= d[7:0] != sh.window;
        if (a == 9'h0C3) sh.window = d[7:0];
        if (a == 9'h0C5) pb |= d != sh.black_lines;
        if (a == 9'h0C5) sh.black_lines = d;
        if (a == 9'h0C6) pd |= d != sh.dummy_lines;
        if (a == 9'h0C6) sh.dummy_lines = d;
        if (a == 9'h0CC) sh.gain = d;
        if (a == 9'h0CE) sync = d;
        if (a inside {[9'h0C7:9'h0CB]}) sh.exposure[a - 9'h0C7] = d;
        tr.black_cal |= a inside {[9'h080:9'h081], 9'h0C5};
        tr.sync_codes |= a inside {[9'h081:9'h087]};
        tr.test_pattern |= a inside {[9'h090:9'h096]};
    endtask : wr

    // one frame start; pending changes blank only when their group is synced
    task automatic frame;
        logic direct;
        check(160'(o_active), 160'(act));
        check(160'(o_transient), 160'(tr));
        direct = sync[9] && seq[3:1] == 3'b010;
        blank = seq[1] & (sync[0] & pb | sync[1] & pd | sync[4] & sync[8] & pw);
        pb &= ~sync[0];
        pd &= ~sync[1];
        pw &= ~sync[4];
        if (sync[0]) act.black_lines = sh.black_lines;
        if (sync[1]) act.dummy_lines = sh.dummy_lines;
        if (sync[4]) {act.subsample, act.binning} = {sh.subsample, sh.binning};
        if (sync[4]) act.window = sh.window;
        if (sync[2]) act.exposure = direct ? sh.exposure : stg.exposure;
        if (sync[2]) stg.exposure = sh.exposure;
        if (sync[3]) act.gain = sh.gain[13] ? stg.gain : sh.gain;
        if (sync[3]) stg.gain = sh.gain;
        tr = '0;
        @(negedge i_core_clk);
        i_frame_start <= 1'b1;
        @(negedge i_core_clk);
        i_frame_start <= 1'b0;
        check(160'(o_active), 160'(act));
        check(160'(o_transient), 160'(tr));
        check(160'(o_blank_frame), 160'(blank));
        check(160'(o_training_pattern), 160'(blank));
    endtask : frame

    // main sequence: reset values, then rolling and triggered phases
    initial
    begin
        void'($urandom(83));
        repeat (12) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_rst_n <= 1'b1;
        foreach (ra[i])
        begin
            host_u.read(ra[i], rd);
            check(160'(rd), 160'(rv[i]));
        end
        for (int ph = 0; ph < 2; ph++)
        begin
            wr(9'h0C0, 16'h0000);
            st = {$urandom, $urandom};
            foreach (sa[i]) wr(sa[i], st[63 - 16 * i -: 16]);
            check(160'({o_clkgen_cfg, o_core_cfg, o_afe_cfg, o_serout_cfg}), 160'(st));
            wr(9'h0C0, ph == 0 ? 16'h0003 : 16'h0005);
            check(160'({o_seq_mode, o_seq_enable}), 160'(seq[6:0]));
            repeat (40)
            begin
                v = 16'($urandom);
                case ($urandom % 8)
                    0: wr(9'h0C5, v);
                    1: wr(9'h0C6, v);
                    2: wr(9'h0CC, v);
                    3: wr(9'h0C7 + 9'($urandom % 5), v);
                    4: wr(9'h0C3, 16'h0001 << ($urandom % 8));
                    5: wr(9'h0C0, 16'({v[8:7], seq[6:0]}));
                    6: wr(9'h0CE, v & 16'h0313 | 16'h000C);
                    default: wr(v[4] ? 9'h080 + 9'(v[2:0]) : 9'h090 + 9'(v[2:0] % 7), v);
                endcase
                if (v[0]) frame();
            end
            frame();
            frame();
        end
        finish_test();
    end

    // watchdog well past the expected few hundred cycles
    initial
    begin
        #200us;
        fail_count++;
        finish_test();
    end
endmodule : scu_config_sync_tb_top

bind scu_config_sync scu_config_sync_assertions chk_u (.*);
